// *** hdl/dtcu_pkg.sv ***
// Purpose: Constants and types of the timer unit
// Assumes: mclk is the oscillator clock itself
// Notes:   Addresses, bit positions, reset values, timing
package dtcu_pkg;

  // Special function register addresses
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h88;
  localparam logic [7:0] ADDR_MODE_SEL    = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW      = 8'h8a;
  localparam logic [7:0] ADDR_T1_LOW      = 8'h8b;
  localparam logic [7:0] ADDR_T0_HIGH     = 8'h8c;
  localparam logic [7:0] ADDR_T1_HIGH     = 8'h8d;

  // Values after reset
  localparam logic [7:0] CTRL_STATUS_RST = 8'h00;
  localparam logic [7:0] MODE_SEL_RST    = 8'h00;
  localparam logic [7:0] COUNT_RST       = 8'h00;
  localparam logic [7:0] RDATA_RST       = 8'h00;

  // Control/status bit positions
  localparam int CS_T1_OVF  = 7;
  localparam int CS_T1_RUN  = 6;
  localparam int CS_T0_OVF  = 5;
  localparam int CS_T0_RUN  = 4;
  localparam int CS_X1_EDGE = 3;
  localparam int CS_X1_TYPE = 2;
  localparam int CS_X0_EDGE = 1;
  localparam int CS_X0_TYPE = 0;

  // Mode select layout: one nibble per timer
  localparam int MS_T1_LSB  = 4;
  localparam int MS_T0_LSB  = 0;
  localparam int MS_GATE    = 3;
  localparam int MS_COUNTER = 2;
  localparam int MS_MODE_HI = 1;
  localparam int MS_MODE_LO = 0;

  // Sampled pin indices
  localparam int PIN_CNT0 = 0;
  localparam int PIN_CNT1 = 1;
  localparam int PIN_IRQ0 = 2;
  localparam int PIN_IRQ1 = 3;
  localparam int PIN_NUM  = 4;

  // Machine cycle: twelve oscillator periods
  localparam int               MC_OSC_PERIODS = 12;
  localparam int               MCLK_PER_OSC   = 1;
  localparam int               CLK_PER_MC     = MC_OSC_PERIODS * MCLK_PER_OSC;
  localparam int               MC_CNT_W       = 4;
  localparam logic [MC_CNT_W-1:0] MC_CNT_RST  = 4'h0;
  localparam logic [MC_CNT_W-1:0] MC_CNT_LAST = MC_CNT_W'(CLK_PER_MC - 1);

  // Thirteen-bit mode prescaler
  localparam logic [4:0] PRESCALE_MAX = 5'h1f;

  typedef enum logic [1:0] {
    DTCU_MODE_13BIT,
    DTCU_MODE_16BIT,
    DTCU_MODE_RELOAD,
    DTCU_MODE_SPLIT
  } dtcu_mode_t;

endpackage

// *** hdl/dtcu_pin_sampler.sv ***
// Purpose: Synchronise pins, sample once per machine cycle
// Assumes: mc_tick pulses once per machine cycle
// Notes:   fall_out holds one machine cycle
`timescale 1ns/1ps
`default_nettype none
module dtcu_pin_sampler #(
  parameter int WIDTH = 4
) (
  // Clock, reset, enable
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Machine cycle strobe
  input  wire logic             mc_tick,
  // Pins
  input  wire logic [WIDTH-1:0] pin_in,
  // Sampled results
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] fall_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      logic sync_a;
      logic sync_b;
      logic samp;
      logic fall;
      logic next_samp;
      logic next_fall;

      always_comb begin
        next_samp = samp;
        next_fall = fall;
        if (mc_tick) begin
          next_samp = sync_b;
          next_fall = samp & ~sync_b;  // [R02] [R04]
        end
      end

      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          sync_a <= 1'b1;
          sync_b <= 1'b1;
          samp   <= 1'b1;
          fall   <= 1'b0;
        end else if (ce) begin
          sync_a <= pin_in[i];  // [R21]
          sync_b <= sync_a;
          samp   <= next_samp;
          fall   <= next_fall;
        end
      end

      assign level_out[i] = sync_b;
      assign fall_out[i]  = fall;
    end
  endgenerate

endmodule // dtcu_pin_sampler
`default_nettype wire

// *** hdl/dtcu_timer_unit.sv ***
// Purpose: Two 16-bit timer/counters and their registers
// Assumes: Register port on the same clock
// Notes:   Reads return one clock after sfr_rd; writes win over counting
//
// Function
// R01: Timer function counts once per twelve oscillator periods
// R02: Counter function counts sampled high-then-low pairs
// R03: Counted edge appears in the register next cycle
// R04: Edge counting limited to one twenty-fourth oscillator
// R05: Outside source holds each level one machine cycle
// R06: Function bit picks internal clock or count pin
// R07: Mode zero is thirteen bits with five-bit prescaler
// R08: Rollover to zero sets that timer's overflow flag
// R09: Run bit, gated by interrupt pin when gate set
// R10: Setting run bit leaves the count untouched
// R11: Mode one cascades both bytes into sixteen bits
// R12: Mode two reloads low byte from high byte
// R13: Timer one in mode three holds its count
// R14: Timer zero mode three splits into two counters
// R15: Timer one still runs, overflows without its flag
// R16: Overflow flags cleared when processor vectors
// R17: Edge flags set on selected trigger, cleared when serviced
// R18: Type bit picks falling edge or low level
// R19: Mode register: timer one high nibble, zero low
// R20: Timer zero code three splits instead of stopping
// R21: Count pins synchronised before falling-edge detection
`timescale 1ns/1ps
`default_nettype none
module dtcu_timer_unit (
  // Clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // Outside pins
  input  wire logic       count_pin_zero,
  input  wire logic       count_pin_one,
  input  wire logic       ext_irq_zero_pin,
  input  wire logic       ext_irq_one_pin,
  // Interrupt vector acknowledges from the core
  input  wire logic       ack_timer_zero,
  input  wire logic       ack_timer_one,
  input  wire logic       ack_ext_irq_zero,
  input  wire logic       ack_ext_irq_one,
  // Flags and overflow strobe
  output logic            timer_zero_overflow_flag,
  output logic            timer_one_overflow_flag,
  output logic            ext_irq_zero_edge_flag,
  output logic            ext_irq_one_edge_flag,
  output logic            timer_one_overflow_pulse
);

  // Machine cycle prescaler
  logic [dtcu_pkg::MC_CNT_W-1:0] mc_cnt;
  logic [dtcu_pkg::MC_CNT_W-1:0] next_mc_cnt;
  logic                          mc_tick;

  // Registers and their next values
  logic [7:0] timer_control_status;
  logic [7:0] timer_mode_select;
  logic [7:0] timer_zero_low_byte;
  logic [7:0] timer_zero_high_byte;
  logic [7:0] timer_one_low_byte;
  logic [7:0] timer_one_high_byte;
  logic [7:0] next_control_status;
  logic [7:0] next_mode_select;
  logic [7:0] next_t0_low;
  logic [7:0] next_t0_high;
  logic [7:0] next_t1_low;
  logic [7:0] next_t1_high;
  logic       next_t1_pulse;
  logic [7:0] next_rdata;

  // Raw pin vector and sampled pins
  logic [dtcu_pkg::PIN_NUM-1:0] pin_vec;
  logic [dtcu_pkg::PIN_NUM-1:0] pin_level;
  logic [dtcu_pkg::PIN_NUM-1:0] pin_fall;

  // Decoded controls
  logic [3:0]           t0_ctl;
  logic [3:0]           t1_ctl;
  dtcu_pkg::dtcu_mode_t t0_mode;
  dtcu_pkg::dtcu_mode_t t1_mode;
  logic                 t0_enable;
  logic                 t1_enable;
  logic                 t0_inc;
  logic                 t1_inc;
  logic                 t0_high_inc;
  logic                 t0_ovf;
  logic                 t0_high_ovf;
  logic                 t1_ovf;
  logic                 t0_set;
  logic                 t1_set;
  logic                 x0_set;
  logic                 x1_set;
  logic [4:0]           t0_pre;
  logic [4:0]           t1_pre;

  assign pin_vec = {ext_irq_one_pin, ext_irq_zero_pin, count_pin_one, count_pin_zero};

  dtcu_pin_sampler #(
    .WIDTH (dtcu_pkg::PIN_NUM)
  ) u_sampler (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .mc_tick   (mc_tick),
    .pin_in    (pin_vec),
    .level_out (pin_level),
    .fall_out  (pin_fall)
  );

  // One tick in every twelve clocks
  assign mc_tick = (mc_cnt == dtcu_pkg::MC_CNT_LAST);  // [R01]

  always_comb begin
    if (mc_tick) begin
      next_mc_cnt = dtcu_pkg::MC_CNT_RST;
    end else begin
      next_mc_cnt = mc_cnt + 4'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mc_cnt <= dtcu_pkg::MC_CNT_RST;
    end else if (ce) begin
      mc_cnt <= next_mc_cnt;
    end
  end

  // Control decode
  assign t1_ctl  = timer_mode_select[dtcu_pkg::MS_T1_LSB +: 4];  // [R19]
  assign t0_ctl  = timer_mode_select[dtcu_pkg::MS_T0_LSB +: 4];  // [R19]
  assign t0_mode = dtcu_pkg::dtcu_mode_t'(t0_ctl[dtcu_pkg::MS_MODE_HI:dtcu_pkg::MS_MODE_LO]);
  assign t1_mode = dtcu_pkg::dtcu_mode_t'(t1_ctl[dtcu_pkg::MS_MODE_HI:dtcu_pkg::MS_MODE_LO]);

  // Run bit, gated by the pin level
  assign t0_enable = timer_control_status[dtcu_pkg::CS_T0_RUN]
                   & (~t0_ctl[dtcu_pkg::MS_GATE] | pin_level[dtcu_pkg::PIN_IRQ0]);  // [R09]
  assign t1_enable = timer_control_status[dtcu_pkg::CS_T1_RUN]
                   & (~t1_ctl[dtcu_pkg::MS_GATE] | pin_level[dtcu_pkg::PIN_IRQ1]);  // [R09]

  // Tick, or an edge caught in the last machine cycle
  assign t0_inc = mc_tick & t0_enable
                & (t0_ctl[dtcu_pkg::MS_COUNTER] ? pin_fall[dtcu_pkg::PIN_CNT0] : 1'b1);  // [R06] [R03]
  assign t1_inc = mc_tick & t1_enable & (t1_mode != dtcu_pkg::DTCU_MODE_SPLIT)  // [R13]
                & (t1_ctl[dtcu_pkg::MS_COUNTER] ? pin_fall[dtcu_pkg::PIN_CNT1] : 1'b1);  // [R06] [R03]

  // Split high byte: ticks only, under timer one's run bit
  assign t0_high_inc = mc_tick & (t0_mode == dtcu_pkg::DTCU_MODE_SPLIT)
                     & timer_control_status[dtcu_pkg::CS_T1_RUN];  // [R14]

  assign t0_pre = timer_zero_low_byte[4:0];
  assign t1_pre = timer_one_low_byte[4:0];

  // Counter datapath
  always_comb begin
    next_t0_low  = timer_zero_low_byte;
    next_t0_high = timer_zero_high_byte;
    next_t1_low  = timer_one_low_byte;
    next_t1_high = timer_one_high_byte;
    t0_ovf       = 1'b0;
    t0_high_ovf  = 1'b0;
    t1_ovf       = 1'b0;

    case (t0_mode)
      dtcu_pkg::DTCU_MODE_13BIT: begin
        if (t0_inc) begin
          // Low-byte bits 7:5 untouched
          next_t0_low[4:0] = t0_pre + 5'h01;  // [R07]
          if (t0_pre == dtcu_pkg::PRESCALE_MAX) begin
            next_t0_high = timer_zero_high_byte + 8'h01;
            t0_ovf       = (timer_zero_high_byte == 8'hff);  // [R08]
          end
        end
      end
      dtcu_pkg::DTCU_MODE_16BIT: begin
        if (t0_inc) begin
          {next_t0_high, next_t0_low} = {timer_zero_high_byte, timer_zero_low_byte} + 16'h0001;  // [R11]
          t0_ovf = ({timer_zero_high_byte, timer_zero_low_byte} == 16'hffff);  // [R08]
        end
      end
      dtcu_pkg::DTCU_MODE_RELOAD: begin
        if (t0_inc) begin
          if (timer_zero_low_byte == 8'hff) begin
            next_t0_low = timer_zero_high_byte;  // [R12]
            t0_ovf      = 1'b1;
          end else begin
            next_t0_low = timer_zero_low_byte + 8'h01;
          end
        end
      end
      dtcu_pkg::DTCU_MODE_SPLIT: begin
        if (t0_inc) begin
          next_t0_low = timer_zero_low_byte + 8'h01;  // [R14] [R20]
          t0_ovf      = (timer_zero_low_byte == 8'hff);
        end
        if (t0_high_inc) begin
          next_t0_high = timer_zero_high_byte + 8'h01;  // [R14]
          t0_high_ovf  = (timer_zero_high_byte == 8'hff);
        end
      end
      default: begin
        next_t0_low = timer_zero_low_byte;
      end
    endcase

    case (t1_mode)
      dtcu_pkg::DTCU_MODE_13BIT: begin
        if (t1_inc) begin
          next_t1_low[4:0] = t1_pre + 5'h01;  // [R07]
          if (t1_pre == dtcu_pkg::PRESCALE_MAX) begin
            next_t1_high = timer_one_high_byte + 8'h01;
            t1_ovf       = (timer_one_high_byte == 8'hff);  // [R08]
          end
        end
      end
      dtcu_pkg::DTCU_MODE_16BIT: begin
        if (t1_inc) begin
          {next_t1_high, next_t1_low} = {timer_one_high_byte, timer_one_low_byte} + 16'h0001;  // [R11]
          t1_ovf = ({timer_one_high_byte, timer_one_low_byte} == 16'hffff);  // [R08]
        end
      end
      dtcu_pkg::DTCU_MODE_RELOAD: begin
        if (t1_inc) begin
          if (timer_one_low_byte == 8'hff) begin
            next_t1_low = timer_one_high_byte;  // [R12]
            t1_ovf      = 1'b1;
          end else begin
            next_t1_low = timer_one_low_byte + 8'h01;
          end
        end
      end
      default: begin
        // Mode three holds the count
        next_t1_low = timer_one_low_byte;  // [R13]
      end
    endcase

    // Software writes beat counting
    if (sfr_wr) begin
      case (sfr_addr)
        dtcu_pkg::ADDR_T0_LOW:  next_t0_low  = sfr_wdata;
        dtcu_pkg::ADDR_T0_HIGH: next_t0_high = sfr_wdata;
        dtcu_pkg::ADDR_T1_LOW:  next_t1_low  = sfr_wdata;
        dtcu_pkg::ADDR_T1_HIGH: next_t1_high = sfr_wdata;
        default: begin
          next_t0_low = next_t0_low;
        end
      endcase
    end
  end

  // Flag set conditions
  assign t0_set = t0_ovf;  // [R08]
  // Split high byte takes timer one's flag
  assign t1_set = (t0_mode == dtcu_pkg::DTCU_MODE_SPLIT) ? t0_high_ovf : t1_ovf;  // [R14] [R15]
  assign x0_set = timer_control_status[dtcu_pkg::CS_X0_TYPE]
                ? (mc_tick & pin_fall[dtcu_pkg::PIN_IRQ0])
                : (mc_tick & ~pin_level[dtcu_pkg::PIN_IRQ0]);  // [R18] [R17]
  assign x1_set = timer_control_status[dtcu_pkg::CS_X1_TYPE]
                ? (mc_tick & pin_fall[dtcu_pkg::PIN_IRQ1])
                : (mc_tick & ~pin_level[dtcu_pkg::PIN_IRQ1]);  // [R18] [R17]

  // Status, mode, read data, pulse
  always_comb begin
    next_control_status = timer_control_status;
    next_mode_select    = timer_mode_select;
    next_rdata          = sfr_rdata;
    next_t1_pulse       = t1_ovf;

    // Vector clears; a same-cycle set wins below
    if (ack_timer_zero) begin
      next_control_status[dtcu_pkg::CS_T0_OVF] = 1'b0;  // [R16]
    end
    if (ack_timer_one) begin
      next_control_status[dtcu_pkg::CS_T1_OVF] = 1'b0;  // [R16]
    end
    if (ack_ext_irq_zero) begin
      next_control_status[dtcu_pkg::CS_X0_EDGE] = 1'b0;  // [R17]
    end
    if (ack_ext_irq_one) begin
      next_control_status[dtcu_pkg::CS_X1_EDGE] = 1'b0;  // [R17]
    end

    // Run bit writes touch no count register
    if (sfr_wr && (sfr_addr == dtcu_pkg::ADDR_CTRL_STATUS)) begin
      next_control_status = sfr_wdata;  // [R10]
    end
    if (sfr_wr && (sfr_addr == dtcu_pkg::ADDR_MODE_SEL)) begin
      next_mode_select = sfr_wdata;  // [R19]
    end

    if (t0_set) begin
      next_control_status[dtcu_pkg::CS_T0_OVF] = 1'b1;  // [R08] [R16]
    end
    if (t1_set) begin
      next_control_status[dtcu_pkg::CS_T1_OVF] = 1'b1;  // [R08] [R16]
    end
    if (x0_set) begin
      next_control_status[dtcu_pkg::CS_X0_EDGE] = 1'b1;  // [R17]
    end
    if (x1_set) begin
      next_control_status[dtcu_pkg::CS_X1_EDGE] = 1'b1;  // [R17]
    end

    if (sfr_rd) begin
      case (sfr_addr)
        dtcu_pkg::ADDR_CTRL_STATUS: next_rdata = timer_control_status;
        dtcu_pkg::ADDR_MODE_SEL:    next_rdata = timer_mode_select;
        dtcu_pkg::ADDR_T0_LOW:      next_rdata = timer_zero_low_byte;
        dtcu_pkg::ADDR_T0_HIGH:     next_rdata = timer_zero_high_byte;
        dtcu_pkg::ADDR_T1_LOW:      next_rdata = timer_one_low_byte;
        dtcu_pkg::ADDR_T1_HIGH:     next_rdata = timer_one_high_byte;
        default:                    next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      timer_control_status     <= dtcu_pkg::CTRL_STATUS_RST;
      timer_mode_select        <= dtcu_pkg::MODE_SEL_RST;
      timer_zero_low_byte      <= dtcu_pkg::COUNT_RST;
      timer_zero_high_byte     <= dtcu_pkg::COUNT_RST;
      timer_one_low_byte       <= dtcu_pkg::COUNT_RST;
      timer_one_high_byte      <= dtcu_pkg::COUNT_RST;
      sfr_rdata                <= dtcu_pkg::RDATA_RST;
      timer_one_overflow_pulse <= 1'b0;
    end else if (ce) begin
      timer_control_status     <= next_control_status;
      timer_mode_select        <= next_mode_select;
      timer_zero_low_byte      <= next_t0_low;
      timer_zero_high_byte     <= next_t0_high;
      timer_one_low_byte       <= next_t1_low;
      timer_one_high_byte      <= next_t1_high;
      sfr_rdata                <= next_rdata;
      timer_one_overflow_pulse <= next_t1_pulse;  // [R15]
    end
  end

  // Flags are status register bits
  assign timer_zero_overflow_flag = timer_control_status[dtcu_pkg::CS_T0_OVF];
  assign timer_one_overflow_flag  = timer_control_status[dtcu_pkg::CS_T1_OVF];
  assign ext_irq_zero_edge_flag   = timer_control_status[dtcu_pkg::CS_X0_EDGE];
  assign ext_irq_one_edge_flag    = timer_control_status[dtcu_pkg::CS_X1_EDGE];

endmodule // dtcu_timer_unit
`default_nettype wire

// *** test/dtcu_properties.sv ***
// Purpose: Port properties of the timer unit
// Assumes: Tick on every twelfth enabled clock
// Notes:   Bind at the end
`timescale 1ns/1ps
`default_nettype none
module dtcu_properties (
  // Clock and control
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       ce,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Pin and acknowledges
  input wire logic       ext_irq_zero_pin,
  input wire logic       ack_timer_zero,
  input wire logic       ack_timer_one,
  // Flags and overflow pulse
  input wire logic       timer_zero_overflow_flag,
  input wire logic       timer_one_overflow_flag,
  input wire logic       ext_irq_zero_edge_flag,
  input wire logic       timer_one_overflow_pulse
);
  logic [3:0] phase, next_phase;
  logic [4:0] low_cnt, next_low_cnt;
  logic       type0, next_type0, tick, cs_wr, set_ok;

  // Mirrors prescaler, level type, pin-low time
  always_comb begin
    tick = ce && phase == 4'hb;
    cs_wr = ce && sfr_wr && sfr_addr == dtcu_pkg::ADDR_CTRL_STATUS;
    set_ok = tick || cs_wr;
    next_phase = tick ? 4'h0 : phase + 4'(ce);
    next_type0 = cs_wr ? sfr_wdata[dtcu_pkg::CS_X0_TYPE] : type0;
    next_low_cnt = ext_irq_zero_pin ? 5'h00 : low_cnt + 5'(low_cnt != 5'h1f);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase   <= 4'h0;
      low_cnt <= 5'h00;
      type0   <= 1'b0;
    end else begin
      phase   <= next_phase;
      low_cnt <= next_low_cnt;
      type0   <= next_type0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_T0_ACK_CLEARS: assert property (ack_timer_zero && !set_ok |=> !timer_zero_overflow_flag)
    else $error("t0 flag kept after ack");
  AST_T1_ACK_CLEARS: assert property (ack_timer_one && !set_ok |=> !timer_one_overflow_flag)
    else $error("t1 flag kept after ack");
  AST_T0_SET_AT_TICK: assert property ($rose(timer_zero_overflow_flag) |-> $past(set_ok))
    else $error("t0 flag rose off tick");
  AST_X0_SET_AT_TICK: assert property ($rose(ext_irq_zero_edge_flag) |-> $past(set_ok))
    else $error("x0 flag rose off tick");
  AST_LEVEL_SETS: assert property (tick && !type0 && low_cnt == 5'h1f |=> ext_irq_zero_edge_flag)
    else $error("low level missed x0 flag");
  AST_PULSE_NEAR_TICK: assert property (timer_one_overflow_pulse |-> $past(tick) || $past(tick, 2))
    else $error("t1 pulse off tick");
  AST_PULSE_SPACED: assert property (timer_one_overflow_pulse |=> !timer_one_overflow_pulse [*8])
    else $error("t1 pulses too close");
  AST_RDATA_HOLDS: assert property (!(ce && sfr_rd) |=> $stable(sfr_rdata))
    else $error("rdata moved without read");
  AST_UNMAPPED_ZERO: assert property (ce && sfr_rd && (sfr_addr < 8'h88 || sfr_addr > 8'h8d)
    |=> sfr_rdata == 8'h00) else $error("unmapped read nonzero");

  cover property (timer_one_overflow_pulse);
  cover property (timer_zero_overflow_flag && ack_timer_zero);
  cover property (ext_irq_zero_edge_flag && type0);
  cover property (ext_irq_zero_edge_flag && !type0);
endmodule // dtcu_properties

bind dtcu_timer_unit dtcu_properties i_props (
  .mclk(mclk), .rst(rst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .ext_irq_zero_pin(ext_irq_zero_pin), .ack_timer_zero(ack_timer_zero),
  .ack_timer_one(ack_timer_one), .timer_zero_overflow_flag(timer_zero_overflow_flag),
  .timer_one_overflow_flag(timer_one_overflow_flag),
  .ext_irq_zero_edge_flag(ext_irq_zero_edge_flag),
  .timer_one_overflow_pulse(timer_one_overflow_pulse)
);
`default_nettype wire

// *** test/dtcu_pin_model.sv ***
// Purpose: Count and interrupt pin sources
// Assumes: Tasks are called just after a rising edge
// Notes:   Pins idle high
`timescale 1ns/1ps
`default_nettype none
module dtcu_pin_model (
  // Clock
  input  wire logic       mclk,
  // Pins {irq one, irq zero, count one, count zero}
  output var  logic [3:0] pins
);
  initial pins = 4'hf;

  task automatic send_falls(input int idx, input int n, input int half);
    int h;
    h = half < 12 ? 12 : half;
    repeat (n) begin
      repeat (h) @(posedge mclk);
      #1 pins[idx] = 1'b0;
      repeat (h) @(posedge mclk);
      #1 pins[idx] = 1'b1;
    end
  endtask

  task automatic set_pin(input int idx, input logic lvl);
    @(posedge mclk);
    #1 pins[idx] = lvl;
  endtask
endmodule // dtcu_pin_model
`default_nettype wire

// *** test/dtcu_timer_unit_test.sv ***
// Purpose: Self-checking bench for the timer unit
// Assumes: ce held high
// Notes:   Random values from an LFSR that starts at 84787
`timescale 1ns/1ps
`default_nettype none
module dtcu_timer_unit_test;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [3:0]  ackv = 4'h0;
  logic [3:0]  mc_phase = 4'h0;
  logic [31:0] lfsr = 32'h0001_4b33;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          pulse_cnt = 0;
  wire  [7:0]  sfr_rdata;
  wire  [3:0]  pins;
  wire  [3:0]  flags;
  wire         pulse;

  dtcu_pin_model i_pins (.mclk(mclk), .pins(pins));
  dtcu_timer_unit i_dut (
    .mclk(mclk), .rst(rst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .count_pin_zero(pins[0]), .count_pin_one(pins[1]),
    .ext_irq_zero_pin(pins[2]), .ext_irq_one_pin(pins[3]),
    .ack_timer_zero(ackv[0]), .ack_timer_one(ackv[1]),
    .ack_ext_irq_zero(ackv[2]), .ack_ext_irq_one(ackv[3]),
    .timer_zero_overflow_flag(flags[0]), .timer_one_overflow_flag(flags[1]),
    .ext_irq_zero_edge_flag(flags[2]), .ext_irq_one_edge_flag(flags[3]),
    .timer_one_overflow_pulse(pulse)
  );

  always #5 mclk = ~mclk;

  // Machine-cycle phase
  always @(posedge mclk) begin
    if (rst) mc_phase <= 4'h0;
    else if (ce) mc_phase <= (mc_phase == 4'hb) ? 4'h0 : mc_phase + 4'h1;
    if (pulse) pulse_cnt <= pulse_cnt + 1;
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  // Count after n ticks: {overflow, high, low}
  function automatic logic [16:0] model(input logic [1:0] m, input logic [15:0] v, input int n);
    logic        f;
    logic [12:0] t;
    f = 1'b0;
    repeat (n) begin
      t = {v[15:8], v[4:0]};
      if (m == 2'd0) begin
        f |= (t == 13'h1fff);
        t = t + 13'h0001;
        v = {t[12:5], v[7:5], t[4:0]};
      end else if (m == 2'd1) begin
        f |= (v == 16'hffff);
        v = v + 16'h0001;
      end else begin
        f |= (v[7:0] == 8'hff);
        v[7:0] = (v[7:0] == 8'hff) ? v[15:8] : v[7:0] + 8'h01;
      end
    end
    return {f, v};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic clk(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    clk(1);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    clk(1);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    clk(1);
    sfr_rd = 1'b1;
    sfr_addr = a;
    clk(1);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask

  task automatic wcs(input logic [7:0] d);
    wr(dtcu_pkg::ADDR_CTRL_STATUS, d);
  endtask

  task automatic rd16(input logic one, output logic [15:0] v);
    rd(one ? dtcu_pkg::ADDR_T1_LOW : dtcu_pkg::ADDR_T0_LOW, v[7:0]);
    rd(one ? dtcu_pkg::ADDR_T1_HIGH : dtcu_pkg::ADDR_T0_HIGH, v[15:8]);
  endtask

  task automatic load(input logic [7:0] md, input logic [15:0] t0, input logic [15:0] t1);
    wr(dtcu_pkg::ADDR_MODE_SEL, md);
    wr(dtcu_pkg::ADDR_T0_LOW, t0[7:0]);
    wr(dtcu_pkg::ADDR_T0_HIGH, t0[15:8]);
    wr(dtcu_pkg::ADDR_T1_LOW, t1[7:0]);
    wr(dtcu_pkg::ADDR_T1_HIGH, t1[15:8]);
  endtask

  task automatic ack(input logic [3:0] m);
    ackv = m;
    clk(1);
    ackv = 4'h0;
  endtask

  // Starts after a tick; n ticks pass
  task automatic timed_run(input logic [7:0] run, input int n);
    do clk(1); while (mc_phase != 4'h0);
    wcs(run);
    repeat (12 * n - 2) @(posedge mclk);
    #1;
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin : watchdog
    repeat (20000) @(posedge mclk);
    n_errors++;
    $display("Watchdog expired");
    results();
  end

  initial begin : main
    logic [7:0]  a, b, hi, lo;
    logic [15:0] v, t1v;
    logic [16:0] e;
    int          n, p0;
    repeat (16) @(posedge mclk);
    #1 rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(i == 6 ? 8'h90 : 8'h88 + 8'(i), a);
      check(16'(a), 16'h0000);
    end
    repeat (4) begin
      b = rnd();
      wr(dtcu_pkg::ADDR_MODE_SEL, b);
      rd(dtcu_pkg::ADDR_MODE_SEL, a);
      check(16'(a), 16'(b));
    end
    $display("Test registers done");
    for (int m = 0; m < 3; m++) begin
      repeat (2) begin
        hi = (m == 2) ? rnd() : 8'hff;
        lo = (m == 2) ? 8'hff - (rnd() & 8'h07) : rnd() | (m == 0 ? 8'h18 : 8'hf0);
        n = int'(rnd() & 8'h0f) + 1;
        t1v = {rnd(), rnd()};
        load(8'h30 | 8'(m), {hi, lo}, t1v);
        e = model(2'(m), {hi, lo}, n);
        timed_run(8'h50, n);
        check(16'(flags[0]), 16'(e[16]));
        ack(4'h1);
        check(16'(flags[0]), 16'h0000);
        wcs(8'h00);
        rd16(1'b0, v);
        check(v, e[15:0]);
        rd16(1'b1, v);
        check(v, t1v);
      end
    end
    $display("Test timer modes done");
    for (int i = 0; i < 2; i++) begin
      hi = (i == 1) ? 8'hff : 8'h10;
      load(8'h13, {hi, 8'hfe}, 16'hfffe);
      p0 = pulse_cnt;
      timed_run(8'h50, 3);
      check(16'(flags[1:0]), {14'h0000, hi == 8'hff, 1'b1});
      ack(4'h3);
      check(16'(flags[1:0]), 16'h0000);
      wcs(8'h00);
      check(16'(pulse_cnt - p0), 16'h0001);
      rd16(1'b0, v);
      check(v, {hi + 8'h03, 8'h01});
      rd16(1'b1, v);
      check(v, 16'h0001);
    end
    $display("Test split mode done");
    for (int j = 0; j < 3; j++) begin
      load(8'h50, 16'h0000, 16'h0000);
      wcs(j < 2 ? 8'h40 : 8'h00);
      n = int'(rnd() & 8'h03) + 2;
      i_pins.send_falls(1, n, j == 0 ? 12 : int'(rnd() & 8'h0f) + 13);
      clk(48);
      wcs(8'h00);
      rd16(1'b1, v);
      check(v, j < 2 ? 16'(n) : 16'h0000);
    end
    i_pins.set_pin(3, 1'b0);
    load(8'h90, 16'h0000, 16'h0000);
    wcs(8'h40);
    clk(60);
    rd(dtcu_pkg::ADDR_T1_LOW, a);
    check(16'(a), 16'h0000);
    i_pins.set_pin(3, 1'b1);
    clk(96);
    rd(dtcu_pkg::ADDR_T1_LOW, a);
    check(16'(a >= 8'h06 && a <= 8'h09), 16'h0001);
    wcs(8'h00);
    $display("Test counter and gate done");
    for (int i = 0; i < 2; i++) begin
      wcs(i == 1 ? 8'h04 : 8'h01);
      i_pins.send_falls(2 + i, 1, 14);
      clk(30);
      check(16'(flags[2 + i]), 16'h0001);
      ack(4'h4 << i);
      clk(30);
      check(16'(flags[2 + i]), 16'h0000);
      wcs(8'h00);
      i_pins.set_pin(2 + i, 1'b0);
      clk(40);
      ack(4'h4 << i);
      clk(24);
      check(16'(flags[2 + i]), 16'h0001);
      i_pins.set_pin(2 + i, 1'b1);
      clk(30);
      ack(4'h4 << i);
      clk(24);
      check(16'(flags[2 + i]), 16'h0000);
    end
    $display("Test interrupts done");
    results();
  end
endmodule // dtcu_timer_unit_test
`default_nettype wire
